/* File: sopc_top.sv */
// Operational control registers: sample period, sleep, output level, I/O lines,
// data-ready, self-test and flash write accounting, reached over the serial port.
// Assumes flash image, alarm and capture signals come from logic on mclk_in.
//
// Overview of operation
// - Sample period equals time base times one plus seven-bit multiplier.
// - Bit 7 picks time base: 122.07 us when clear, 3.784 ms when set.
// - Sample period defaults to 0x0001 and is kept as a flash setting.
// - Output data update once per sample period, independent of host reads.
// - Sleep write shuts device down count times half a second, then resumes.
// - Output level register holds twelve bits, resets to zero, is volatile.
// - Converter level holds while host writes the level bytes.
// - Command bit 2 copies the level register into the converter latch.
// - I/O control bits 0 and 1 set line direction, 1 is output.
// - Bits 8 and 9 drive output lines; inputs read the sampled pin.
// - Line ownership: general-purpose first, then data-ready, then alarm.
// - Diag bit 2 enables data-ready, bit 1 polarity, bit 0 line select.
// - Data-ready pulses once per sample at twenty percent duty.
// - Host starts self-test with diag bit 8, waits 35 ms, reads status.
// - Self-test start bit clears itself when the test finishes.
// - A failed self-test sets the error flag, zero means normal.
// - Self-test runs after power-on unless diag bit 10 is set.
// - No new-data indication while a self-test runs.
// - With diag bit 11 set, a full capture buffer is copied to flash.
// - Flash write counter counts every flash write and wraps after 32767.
`timescale 1ns/10ps
module sopc_top import sopc_pkg::*; #(
    parameter int unsigned TB_FAST = TB_FAST_CYC,
    parameter int unsigned TB_SLOW = TB_SLOW_CYC,
    parameter int unsigned SLEEP_STEP = SLEEP_STEP_CYC,
    parameter int unsigned SELFTEST = SELFTEST_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Serial port pins
    input wire logic sclk_in,
    input wire logic cs_b_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    // Digital I/O lines
    input wire logic [1:0] dio_in,
    output logic [1:0] dio_out,
    output logic [1:0] dio_oe_out,
    // Alarm requests for the lines
    input wire logic [1:0] alarm_en_in,
    input wire logic [1:0] alarm_lvl_in,
    // Flash image and flash activity
    input wire logic [15:0] nv_sample_in,
    input wire logic [15:0] nv_diag_in,
    output logic [15:0] nv_sample_out,
    output logic [15:0] nv_diag_out,
    output logic flash_save_out,
    output logic capt_copy_out,
    // Capture engine
    input wire logic capt_full_in,
    // Sensor side
    input wire logic st_fail_in,
    output logic st_active_out,
    output logic selftest_error_out,
    output logic sample_update_out,
    output logic sleep_out,
    output logic [11:0] dac_code_out
);
    localparam logic [31:0] SLP_LOAD = 32'(SLEEP_STEP - 1);
    localparam logic [31:0] ST_LOAD = 32'(SELFTEST - 1);

    sopc_frame_s frm;
    logic frm_vld;
    logic [15:0] rd_word;
    logic [5:0] rd_sel;
    logic boot;
    logic [15:0] smpl;
    logic [15:0] aout;
    logic [15:0] dio;
    logic [15:0] diag;
    logic [14:0] flash_cnt;
    logic [7:0] sleep_steps;
    logic [31:0] sleep_cyc;
    logic st_busy;
    logic [31:0] st_cyc;
    logic st_err;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] dio_rd;
    logic [1:0] next_dio_o;
    logic [1:0] next_dio_oe;
    logic tick;
    logic tmr_active;

    // Byte write into a 16-bit register, keeping only implemented bits
    function automatic logic [15:0] sopc_bwr(input logic [15:0] old, input logic hi,
        input logic [7:0] d, input logic [15:0] mask);
        logic [15:0] v;
        v = hi ? {d, old[7:0]} : {old[15:8], d};
        return v & mask;
    endfunction : sopc_bwr

    sopc_spi u_spi (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .sclk_in(sclk_in),
        .cs_b_in(cs_b_in),
        .mosi_in(mosi_in),
        .miso_out(miso_out),
        .miso_oe_out(miso_oe_out),
        .rdata_in(rd_word),
        .frame_out(frm),
        .frame_vld_out(frm_vld)
    );

    // Write decode; settings registers are hit by either byte of their pair, sleep and command by their even byte only
    wire wr_any = frm_vld && frm.wr;
    wire [5:0] wsel = frm.addr[6:1];
    wire wr_aout = wr_any && (wsel == ADDR_AOUT[6:1]);
    wire wr_dio = wr_any && (wsel == ADDR_DIO[6:1]);
    wire wr_diag = wr_any && (wsel == ADDR_DIAG[6:1]);
    wire wr_smpl = wr_any && (wsel == ADDR_SMPL[6:1]);
    wire wr_sleep = wr_any && (frm.addr == ADDR_SLEEP);
    wire wr_cmd = wr_any && (frm.addr == ADDR_CMD);
    wire cmd_latch = wr_cmd && frm.data[CMD_DAC_LATCH];
    wire cmd_fupd = wr_cmd && frm.data[CMD_FLASH_UPD];
    wire cmd_sclr = wr_cmd && frm.data[CMD_STAT_CLR];
    wire cmd_copy = wr_cmd && frm.data[CMD_CAPT_COPY];

    // Next values of the settings; the first cycle after reset loads the flash image
    wire [15:0] next_smpl = boot ? (nv_sample_in & SMPL_MASK) :
        wr_smpl ? sopc_bwr(smpl, frm.addr[0], frm.data, SMPL_MASK) : smpl;
    wire [15:0] next_diag = boot ? (nv_diag_in & DIAG_MASK) :
        wr_diag ? sopc_bwr(diag, frm.addr[0], frm.data, DIAG_MASK) : diag;
    wire [15:0] next_aout = wr_aout ? sopc_bwr(aout, frm.addr[0], frm.data, AOUT_MASK) : aout;
    wire [15:0] next_dio = wr_dio ? sopc_bwr(dio, frm.addr[0], frm.data, DIO_MASK) : dio;

    // Settings registers
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            boot <= 1'b1;
            smpl <= SMPL_RST;
            diag <= DIAG_RST;
            aout <= AOUT_RST;
            dio <= DIO_RST;
        end else begin
            boot <= 1'b0;
            smpl <= next_smpl;
            diag <= next_diag;
            aout <= next_aout;
            dio <= next_dio;
        end
    end

    // Converter latch only moves on the latch command, so byte writes never glitch it
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dac_code_out <= AOUT_RST[11:0];
        end else if (cmd_latch) begin
            dac_code_out <= aout[11:0];
        end
    end

    // Sleep countdown in half-second steps; writing zero ends it early
    wire sleeping = (sleep_steps != 8'h00);
    wire slp_step = sleeping && (sleep_cyc == 32'h0);
    wire [7:0] next_steps = wr_sleep ? frm.data : slp_step ? sleep_steps - 8'h01 : sleep_steps;
    wire [31:0] next_slp_cyc = (wr_sleep || slp_step) ? SLP_LOAD :
        sleeping ? sleep_cyc - 32'h1 : sleep_cyc;
    assign sleep_out = sleeping;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sleep_steps <= 8'h00;
            sleep_cyc <= 32'h0;
        end else begin
            sleep_steps <= next_steps;
            sleep_cyc <= next_slp_cyc;
        end
    end

    // Self-test: started at boot unless skipped, or by host; restart while busy reloads
    wire st_go = boot ? !nv_diag_in[DIAG_POST_OFF] :
        (wr_diag && frm.addr[0] && frm.data[DIAG_ST_GO - 8]);
    wire st_done = st_busy && (st_cyc == 32'h0);
    wire next_st_busy = st_go || (st_busy && !st_done);
    wire [31:0] next_st_cyc = st_go ? ST_LOAD : st_busy ? st_cyc - 32'h1 : st_cyc;
    wire next_st_err = (st_done && st_fail_in) || (st_err && !cmd_sclr);
    assign st_active_out = st_busy;
    assign selftest_error_out = st_err;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_busy <= 1'b0;
            st_cyc <= 32'h0;
            st_err <= 1'b0;
        end else begin
            st_busy <= next_st_busy;
            st_cyc <= next_st_cyc;
            st_err <= next_st_err;
        end
    end

    // Sample pacing stops entirely while asleep
    sopc_timer #(
        .TB_FAST(TB_FAST),
        .TB_SLOW(TB_SLOW)
    ) u_timer (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .run_in(!sleeping),
        .tb_sel_in(smpl[SMPL_TB]),
        .mult_in(smpl[6:0]),
        .tick_out(tick),
        .active_out(tmr_active)
    );
    assign sample_update_out = tick && !sleeping;

    // Data-ready level, held inactive during self-test and sleep
    wire drdy_act = tmr_active && diag[DIAG_DR_EN] && !st_busy && !sleeping;
    wire drdy_lvl = diag[DIAG_DR_POL] ? drdy_act : !drdy_act;

    // Per-line ownership and readback
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_line
            wire gp = dio[DIO_DIR0 + gi];
            wire dr = diag[DIAG_DR_EN] && (diag[DIAG_DR_SEL] ? (gi == 1) : (gi == 0));
            assign next_dio_oe[gi] = gp || dr || alarm_en_in[gi];
            assign next_dio_o[gi] = gp ? dio[DIO_VAL0 + gi] : dr ? drdy_lvl : alarm_lvl_in[gi];
            assign dio_rd[gi] = gp ? dio[DIO_VAL0 + gi] : pin_s2[gi];
        end
    endgenerate

    // Line drivers from flops; pin levels pass two stages before readback
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dio_out <= 2'h0;
            dio_oe_out <= 2'h0;
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
        end else begin
            dio_out <= next_dio_o;
            dio_oe_out <= next_dio_oe;
            pin_s1 <= dio_in;
            pin_s2 <= pin_s1;
        end
    end

    // Flash requests and write count; the count rolls over at its 15-bit limit
    wire next_copy = cmd_copy || (diag[DIAG_AUTOSAVE] && capt_full_in);
    wire [14:0] next_fcnt = flash_cnt + {14'h0000, flash_save_out} + {14'h0000, capt_copy_out};
    assign nv_sample_out = smpl;
    assign nv_diag_out = diag;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flash_save_out <= 1'b0;
            capt_copy_out <= 1'b0;
            flash_cnt <= FCNT_RST;
        end else begin
            flash_save_out <= cmd_fupd;
            capt_copy_out <= next_copy;
            flash_cnt <= next_fcnt;
        end
    end

    // Read address is remembered from a read frame; data shifts out in the next frame
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_sel <= 6'h00;
        end else if (frm_vld && !frm.wr) begin
            rd_sel <= frm.addr[6:1];
        end
    end

    // Start bit reads back as busy, so it drops by itself when the test ends
    wire [15:0] diag_rd = diag | {7'h00, st_busy, 8'h00};

    // Readback mux; write-only and unmapped words read zero
    assign rd_word = (rd_sel == ADDR_FLASH_CNT[6:1]) ? {1'b0, flash_cnt} :
        (rd_sel == ADDR_AOUT[6:1]) ? aout :
        (rd_sel == ADDR_DIO[6:1]) ? {6'h00, dio_rd, 6'h00, dio[1:0]} :
        (rd_sel == ADDR_DIAG[6:1]) ? diag_rd :
        (rd_sel == ADDR_SMPL[6:1]) ? smpl : 16'h0000;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);

    property p_sleep_quiet;
        sleeping |-> !sample_update_out && !tick && !tmr_active;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("update or data-ready during sleep");

    property p_st_no_drdy;
        st_busy && diag[DIAG_DR_EN] && diag[DIAG_DR_SEL] && !dio[DIO_DIR0 + 1] |=>
            dio_out[1] == !$past(diag[DIAG_DR_POL]);
    endproperty
    a_st_no_drdy: assert property (p_st_no_drdy)
        else $error("data-ready active during self-test");

    property p_dac_hold;
        !cmd_latch |=> $stable(dac_code_out);
    endproperty
    a_dac_hold: assert property (p_dac_hold)
        else $error("converter code moved without latch command");

    property p_dac_latch;
        cmd_latch |=> dac_code_out == $past(aout[11:0]);
    endproperty
    a_dac_latch: assert property (p_dac_latch)
        else $error("converter code not loaded on latch command");

    property p_fcnt_wrap;
        flash_cnt == 15'h7fff && flash_save_out && !capt_copy_out |=> flash_cnt == 15'h0000;
    endproperty
    a_fcnt_wrap: assert property (p_fcnt_wrap)
        else $error("flash write count did not wrap");

    property p_st_self_clear;
        st_done && !st_go |=> !st_busy && !diag_rd[DIAG_ST_GO];
    endproperty
    a_st_self_clear: assert property (p_st_self_clear)
        else $error("self-test start bit did not clear");

    property p_st_fail;
        st_done && st_fail_in |=> st_err;
    endproperty
    a_st_fail: assert property (p_st_fail)
        else $error("failed self-test not flagged");

    property p_sleep_load;
        wr_sleep && frm.data != 8'h00 |=> sleeping && sleep_cyc == SLP_LOAD ##1
            sleeping && sleep_cyc == SLP_LOAD - 32'h1;
    endproperty
    a_sleep_load: assert property (p_sleep_load)
        else $error("sleep countdown not started");

    property p_autosave;
        diag[DIAG_AUTOSAVE] && capt_full_in |=> capt_copy_out ##1 flash_cnt == $past(flash_cnt) + 15'h0001
            || flash_save_out || $past(flash_save_out);
    endproperty
    a_autosave: assert property (p_autosave)
        else $error("full capture buffer not saved");

    property p_gpio_wins;
        dio[DIO_DIR0] |=> dio_oe_out[0] && dio_out[0] == $past(dio[DIO_VAL0]);
    endproperty
    a_gpio_wins: assert property (p_gpio_wins)
        else $error("general-purpose output lost line ownership");
endmodule : sopc_top

/* File: sopc_pkg.sv */
// Shared constants and types for the sensor operational control block.
// Assumes a single 250 MHz clock domain.
package sopc_pkg;
    // Register byte addresses; each 16-bit register spans an even/odd pair
    localparam logic [6:0] ADDR_FLASH_CNT = 7'h00;
    localparam logic [6:0] ADDR_AOUT = 7'h30;
    localparam logic [6:0] ADDR_DIO = 7'h32;
    localparam logic [6:0] ADDR_DIAG = 7'h34;
    localparam logic [6:0] ADDR_SMPL = 7'h36;
    localparam logic [6:0] ADDR_SLEEP = 7'h3a;
    localparam logic [6:0] ADDR_CMD = 7'h3e;
    // Values after reset and writable-bit masks
    localparam logic [15:0] SMPL_RST = 16'h0001;
    localparam logic [15:0] AOUT_RST = 16'h0000;
    localparam logic [15:0] DIO_RST = 16'h0000;
    localparam logic [15:0] DIAG_RST = 16'h0000;
    localparam logic [14:0] FCNT_RST = 15'h0000;
    localparam logic [15:0] SMPL_MASK = 16'h00ff;
    localparam logic [15:0] AOUT_MASK = 16'h0fff;
    localparam logic [15:0] DIO_MASK = 16'h0303;
    localparam logic [15:0] DIAG_MASK = 16'h0c07;
    // Field positions
    localparam int SMPL_TB = 7;
    localparam int DIO_DIR0 = 0;
    localparam int DIO_VAL0 = 8;
    localparam int DIAG_DR_SEL = 0;
    localparam int DIAG_DR_POL = 1;
    localparam int DIAG_DR_EN = 2;
    localparam int DIAG_ST_GO = 8;
    localparam int DIAG_POST_OFF = 10;
    localparam int DIAG_AUTOSAVE = 11;
    localparam int CMD_DAC_LATCH = 2;
    localparam int CMD_FLASH_UPD = 3;
    localparam int CMD_STAT_CLR = 4;
    localparam int CMD_CAPT_COPY = 6;
    // Times in their own units and derived cycle counts at 250 MHz
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TB_FAST_NS = 122070;
    localparam int unsigned TB_SLOW_NS = 3784000;
    localparam int unsigned SLEEP_STEP_MS = 500;
    localparam int unsigned SELFTEST_MS = 35;
    localparam int unsigned TB_FAST_CYC = TB_FAST_NS * CLK_MHZ / 1000;
    localparam int unsigned TB_SLOW_CYC = TB_SLOW_NS * CLK_MHZ / 1000;
    localparam int unsigned SLEEP_STEP_CYC = SLEEP_STEP_MS * CLK_MHZ * 1000;
    localparam int unsigned SELFTEST_CYC = SELFTEST_MS * CLK_MHZ * 1000;
    localparam logic [34:0] DRDY_DUTY_DIV = 35'h5;
    localparam logic [4:0] SPI_BITS = 5'h10;
    // One serial frame: write flag, byte address, write data
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } sopc_frame_s;
endpackage : sopc_pkg

/* File: sopc_spi.sv */
// Serial port slave: 16-bit frames, clock idle high, sampled on rising edge.
// Assumes the serial clock is far slower than mclk_in, so it is oversampled.
`timescale 1ns/10ps
module sopc_spi import sopc_pkg::*; (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Serial pins
    input wire logic sclk_in,
    input wire logic cs_b_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    // Register side
    input wire logic [15:0] rdata_in,
    output sopc_frame_s frame_out,
    output logic frame_vld_out
);
    logic [2:0] sclk_q;
    logic [2:0] cs_q;
    logic [1:0] mosi_q;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [4:0] bits;

    // Edges are seen between second and third stage; first stage feeds only the second
    wire rise = sclk_q[1] && !sclk_q[2];
    wire fall = !sclk_q[1] && sclk_q[2];
    wire sel = !cs_q[1];
    wire start = !cs_q[1] && cs_q[2];
    wire stop = cs_q[1] && !cs_q[2];
    assign miso_out = tx[15];
    assign miso_oe_out = sel;

    // Pin synchronisers, only safe because the host keeps its clock slow
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sclk_q <= 3'h7;
            cs_q <= 3'h7;
            mosi_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], sclk_in};
            cs_q <= {cs_q[1:0], cs_b_in};
            mosi_q <= {mosi_q[0], mosi_in};
        end
    end

    // Shift in on rising edge, shift out on falling edge, close frame on select release
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx <= 16'h0000;
            tx <= 16'h0000;
            bits <= 5'h00;
            frame_out <= '0;
            frame_vld_out <= 1'b0;
        end else begin
            if (rise && sel) begin
                rx <= {rx[14:0], mosi_q[1]};
            end
            if (start) begin
                tx <= rdata_in;
            end else if (fall && sel && bits != 5'h00) begin
                // The first falling edge must not shift: the top bit already stands from select
                tx <= {tx[14:0], 1'b0};
            end
            if (start) begin
                bits <= 5'h00;
            end else if (rise && sel && bits != SPI_BITS) begin
                bits <= bits + 5'h01;
            end
            if (stop) begin
                frame_out <= rx;
            end
            frame_vld_out <= stop && (bits == SPI_BITS); // Short frames are dropped
        end
    end
endmodule : sopc_spi

/* File: sopc_timer.sv */
// Sample period timer: one tick per period and a 20 percent active window.
// Assumes run_in is a same-clock level; the count restarts whenever it falls.
`timescale 1ns/10ps
module sopc_timer import sopc_pkg::*; #(
    parameter int unsigned TB_FAST = TB_FAST_CYC,
    parameter int unsigned TB_SLOW = TB_SLOW_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Control
    input wire logic run_in,
    input wire logic tb_sel_in,
    input wire logic [6:0] mult_in,
    // Outputs
    output logic tick_out,
    output logic active_out
);
    logic [31:0] cnt;

    // Period is time base times one plus multiplier
    wire [31:0] tb = tb_sel_in ? TB_SLOW : TB_FAST;
    wire [31:0] period = 32'(tb * (32'(mult_in) + 32'h1));
    wire [34:0] elapsed5 = 35'(cnt) * DRDY_DUTY_DIV;
    assign tick_out = run_in && (cnt >= period - 32'h1);
    assign active_out = run_in && (elapsed5 < 35'(period));

    // Free-running cycle count within the period
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt <= 32'h0;
        end else begin
            cnt <= (!run_in || tick_out) ? 32'h0 : cnt + 32'h1;
        end
    end

    property p_window_opens;
        @(posedge mclk_in) disable iff (!rst_b_in)
        tick_out && run_in |=> cnt == 32'h0 && (active_out || !run_in);
    endproperty
    a_window_opens: assert property (p_window_opens)
        else $error("active window did not open after tick");
endmodule : sopc_timer

/* File: sopc_host.sv */
// Host model: serial master, clock idle high, data changed on falling edge.
// Assumes xfer is called just after a rising mclk_in edge.
`timescale 1ns/10ps
module sopc_host (
    // Clock
    input wire logic mclk_in,
    // Serial pins
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_b_out,
    output logic mosi_out
);
    // Half serial period in mclk cycles; 50 gives 2.5 MHz, 125 gives 1 MHz
    int half_cyc = 50;
    initial begin
        sclk_out = 1'b1;
        cs_b_out = 1'b1;
        mosi_out = 1'b0;
    end
    // One whole frame; released data line shows the inverse of its last bit
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_b_out <= 1'b0;
        repeat (half_cyc) @(posedge mclk_in);
        for (int i = 15; i >= 0; i--) begin
            sclk_out <= 1'b0;
            mosi_out <= tx[i];
            repeat (half_cyc) @(posedge mclk_in);
            sclk_out <= 1'b1;
            rx[i] = miso_in;
            repeat (half_cyc) @(posedge mclk_in);
        end
        cs_b_out <= 1'b1;
        mosi_out <= ~tx[0];
        repeat (12) @(posedge mclk_in);
    endtask : xfer
endmodule : sopc_host

/* File: sensor_operational_control_tb.sv */
// Testbench: register access over the serial host model, with shortened counts.
// Assumes the flash image holds defaults and power-on self-test is enabled.
`timescale 1ns/10ps
module sensor_operational_control_tb import sopc_pkg::*;;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic sclk, cs_b, mosi, miso, capt_full = 1'b0, st_fail = 1'b0;
    logic [1:0] dio_in = 2'h0, dio_out, dio_oe, alm_en = 2'h0, alm_lvl = 2'h0;
    logic [15:0] nv_s_o, rx, nv_d_o, nv_s_i = 16'h0001, nv_d_i = 16'h0000;
    logic st_act, st_err, upd, sleep;
    logic [11:0] dac;
    logic [6:0] ra [7] = '{ADDR_FLASH_CNT, ADDR_AOUT, ADDR_DIO, ADDR_DIAG, ADDR_SMPL,
        ADDR_SLEEP, 7'h10};
    logic [15:0] re [7] = '{16'h0, AOUT_RST, DIO_RST, DIAG_RST, SMPL_RST, 16'h0, 16'h0};
    int fail_count = 0;
    int checked = 0;
    int n, h;
    // Short counts keep the run well under the cycle budget
    sopc_top #(.TB_FAST(10), .TB_SLOW(40), .SLEEP_STEP(50), .SELFTEST(30)) u_dut (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .sclk_in(sclk), .cs_b_in(cs_b),
        .mosi_in(mosi), .miso_out(miso), .miso_oe_out(), .dio_in(dio_in),
        .dio_out(dio_out), .dio_oe_out(dio_oe), .alarm_en_in(alm_en),
        .alarm_lvl_in(alm_lvl), .nv_sample_in(nv_s_i), .nv_diag_in(nv_d_i),
        .nv_sample_out(nv_s_o), .nv_diag_out(nv_d_o), .flash_save_out(), .capt_copy_out(),
        .capt_full_in(capt_full), .st_fail_in(st_fail), .st_active_out(st_act),
        .selftest_error_out(st_err), .sample_update_out(upd), .sleep_out(sleep),
        .dac_code_out(dac));
    sopc_host u_host (.mclk_in(mclk_in), .miso_in(miso), .sclk_out(sclk),
        .cs_b_out(cs_b), .mosi_out(mosi));
    initial forever #2 mclk_in = ~mclk_in;
    task automatic report_and_stop;
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        u_host.xfer({1'b1, a, d}, rx);
    endtask : wr
    // Read answer arrives in the following frame
    task automatic rd(input string nm, input logic [6:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        u_host.xfer({1'b0, a, 8'h00}, rx);
        u_host.xfer(16'h0000, rx);
        chk(nm, e, rx);
    endtask : rd
    // Cycles between update pulses, sampled at falling edges to avoid races
    task automatic per(output int p);
        p = 0;
        for (int i = 0; i < 2000 && upd !== 1'b1; i++) @(negedge mclk_in);
        do begin
            @(negedge mclk_in);
            p++;
        end while (upd !== 1'b1 && p < 2000);
    endtask : per
    task automatic hi(input int p, output int c);
        c = 0;
        repeat (p) begin
            @(negedge mclk_in);
            c += int'(dio_out[1] === 1'b1);
        end
    endtask : hi
    // Watchdog sized from about 40 frames of 1.6k cycles
    initial begin
        repeat (95000) @(posedge mclk_in);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(negedge mclk_in);
        chk("post", 16'h1, 16'(st_act));
        repeat (40) @(negedge mclk_in);
        chk("post end", 16'h0, 16'(st_act));
        foreach (ra[i]) rd("reset", ra[i], re[i]);
        wr(ADDR_AOUT, 8'hbc);
        wr(7'h31, 8'hfa);
        chk("dac hold", 16'h0, 16'(dac));
        rd("aout", ADDR_AOUT, 16'h0abc);
        wr(ADDR_CMD, 8'h04);
        chk("dac", 16'h0abc, 16'(dac));
        wr(ADDR_SMPL, 8'h03);
        wr(ADDR_DIAG, 8'h07);
        per(n);
        chk("period", 16'd40, 16'(n));
        hi(40, h);
        chk("drdy duty", 16'd8, 16'(h));
        chk("drdy oe", 16'h2, 16'(dio_oe));
        @(posedge mclk_in);
        st_fail <= 1'b1;
        wr(7'h35, 8'h01);
        chk("st run", 16'h1, 16'(st_act));
        hi(20, h);
        chk("st drdy", 16'h0, 16'(h));
        repeat (20) @(negedge mclk_in);
        chk("st end", 16'h0, 16'(st_act));
        chk("st err", 16'h1, 16'(st_err));
        rd("diag", ADDR_DIAG, 16'h0007);
        st_fail <= 1'b0;
        wr(ADDR_CMD, 8'h10);
        chk("err clr", 16'h0, 16'(st_err));
        dio_in <= 2'b01;
        wr(ADDR_DIO, 8'h02);
        wr(7'h33, 8'h00);
        hi(40, h);
        chk("io over drdy", 16'h0, 16'(h));
        rd("dio", ADDR_DIO, 16'h0102);
        alm_en <= 2'b01;
        alm_lvl <= 2'b01;
        repeat (3) @(negedge mclk_in);
        chk("alarm oe", 16'h3, 16'(dio_oe));
        chk("alarm lvl", 16'h1, 16'(dio_out[0]));
        wr(ADDR_SLEEP, 8'h02);
        n = 0;
        h = 0;
        while (sleep === 1'b1 && n < 300) begin
            @(negedge mclk_in);
            n++;
            h += int'(upd === 1'b1);
        end
        chk("sleep len", 16'h1, 16'(n > 85 && n < 100));
        chk("sleep upd", 16'h0, 16'(h));
        wr(ADDR_CMD, 8'h08);
        wr(ADDR_CMD, 8'h40);
        wr(7'h35, 8'h08);
        capt_full <= 1'b1;
        @(posedge mclk_in);
        capt_full <= 1'b0;
        rd("flash cnt", ADDR_FLASH_CNT, 16'h0003);
        wr(ADDR_SMPL, 8'h83);
        u_host.half_cyc = 125;
        per(n);
        chk("slow period", 16'd160, 16'(n));
        chk("nv sample", 16'h0083, nv_s_o);
        // Second reset with the stored image skipping the power-on self-test
        @(posedge mclk_in);
        nv_s_i <= 16'h0107;
        nv_d_i <= 16'h0400;
        rst_b_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(negedge mclk_in);
        chk("post skip", 16'h0, 16'(st_act));
        chk("nv diag", 16'h0400, nv_d_o);
        chk("nv reload", 16'h0007, nv_s_o);
        chk("dac reset", 16'h0, 16'(dac));
        report_and_stop();
    end
endmodule : sensor_operational_control_tb
